// ---- clamp_cal_pkg.sv ----
// Purpose: Constants for the converter clamp and calibration enable regs.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
`default_nettype none
package clamp_cal_pkg;
   localparam logic [7:0]  CAL_EN_OFFSET     = 8'h08;
   localparam logic [7:0]  ARM_CLAMP_OFFSET  = 8'h10;
   localparam logic [15:0] CAL_EN_RESET      = 16'h0000;
   localparam logic [15:0] ARM_CLAMP_RESET   = 16'h0000;
   localparam int          CLAMP_LSB         = 2;
   localparam int          CLAMP_MSB         = 5;
   localparam int          ARM_LSB           = 0;
   localparam int          ARM_MSB           = 1;
   localparam int          CAL_EN_BIT        = 0;
   localparam logic [3:0]  CLAMP_V_9         = 4'h2;
   localparam logic [3:0]  CLAMP_V_15        = 4'h7;
   localparam logic [3:0]  CLAMP_V_18        = 4'h9;
   localparam logic [3:0]  CLAMP_I_LAST      = 4'h9;
endpackage
`default_nettype wire

// ---- clamp_cal_regs.sv ----
// Purpose: APB register bank for converter arm select, negative clamp
//          select and the calibration enable bit of one channel.
// Assumes: Single clock CLK at 20 MHz, asynchronous active-low RST_B.
// Notes:   Zero-wait-state APB slave; unmapped addresses give PSLVERR.
//
// Function
// RULE1 - Bits 5:2 hold a read/write negative clamp code resetting to zero.
// RULE2 - In voltage mode only codes 0010, 0111 and 1001 are valid.
// RULE3 - Arm select bits 1:0 reset to 00 which disables both arms.
// RULE4 - Arm select 01 enables only the positive arm.
// RULE5 - Arm select 10 enables only the negative arm and 11 enables both.
// RULE6 - Calibration enable bit 0 enables data calibration, reset zero.
// RULE7 - Software writes only clamp codes valid for the present mode.
`timescale 1ns/1ps
`default_nettype none
module clamp_cal_regs (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Output mode from the channel, high in voltage mode
   input  wire logic        VOLTAGE_MODE,
   // Converter and calibration controls
   output logic             POS_ARM_EN,
   output logic             NEG_ARM_EN,
   output logic      [3:0]  NEG_CLAMP_CODE,
   output logic             CLAMP_CODE_VALID,
   output logic             CAL_EN
);
   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   logic [3:0] negative_clamp_select_reg;
   logic [1:0] converter_arm_select_reg;
   logic       calibration_enable_bit_reg;
   logic       vmode_s1_reg;
   logic       vmode_reg;
   logic       wr_en;
   logic       hit_cal;
   logic       hit_arm;
   logic [31:0] rdata;

   function automatic logic code_valid(input logic [3:0] code,
                                       input logic vmode);
      if (vmode) begin
         code_valid = (code == clamp_cal_pkg::CLAMP_V_9) ||
                      (code == clamp_cal_pkg::CLAMP_V_15) ||
                      (code == clamp_cal_pkg::CLAMP_V_18);
      end else begin
         code_valid = (code <= clamp_cal_pkg::CLAMP_I_LAST);
      end
   endfunction

   assign hit_cal = (PADDR == clamp_cal_pkg::CAL_EN_OFFSET);
   assign hit_arm = (PADDR == clamp_cal_pkg::ARM_CLAMP_OFFSET);
   assign wr_en   = PSEL && PENABLE && PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit_cal && !hit_arm;

   // ------------------------------------------------------------------
   // Mode pin synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         vmode_s1_reg <= 1'b0;
         vmode_reg    <= 1'b0;
      end else begin
         vmode_s1_reg <= VOLTAGE_MODE;
         vmode_reg    <= vmode_s1_reg;
      end
   end

   // ------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         negative_clamp_select_reg <= clamp_cal_pkg::ARM_CLAMP_RESET[5:2]; // [RULE1]
         converter_arm_select_reg  <= clamp_cal_pkg::ARM_CLAMP_RESET[1:0]; // [RULE3]
      end else if (wr_en && hit_arm) begin
         // Any code is stored as written; validity is only reported.
         negative_clamp_select_reg <= PWDATA[5:2]; // [RULE1]
         converter_arm_select_reg  <= PWDATA[1:0]; // [RULE3]
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         calibration_enable_bit_reg <= clamp_cal_pkg::CAL_EN_RESET[0]; // [RULE6]
      end else if (wr_en && hit_cal) begin
         calibration_enable_bit_reg <= PWDATA[0]; // [RULE6]
      end
   end

   // ------------------------------------------------------------------
   // Read path and outputs
   // ------------------------------------------------------------------
   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_cal) begin
         rdata[0] = calibration_enable_bit_reg;
      end else if (hit_arm) begin
         rdata[5:2] = negative_clamp_select_reg;
         rdata[1:0] = converter_arm_select_reg;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         PRDATA <= rdata;
      end
   end

   assign POS_ARM_EN       = converter_arm_select_reg[0]; // [RULE4] [RULE5]
   assign NEG_ARM_EN       = converter_arm_select_reg[1]; // [RULE4] [RULE5]
   assign NEG_CLAMP_CODE   = negative_clamp_select_reg;
   // High for codes valid in the present mode, low for codes software must not leave in place. [RULE2] [RULE7]
   assign CLAMP_CODE_VALID = code_valid(negative_clamp_select_reg, vmode_reg);
   assign CAL_EN           = calibration_enable_bit_reg; // [RULE6]

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_clamp_write;
      @(posedge CLK) disable iff (!RST_B)
      (wr_en && hit_arm) |=> (NEG_CLAMP_CODE == $past(PWDATA[5:2]));
   endproperty
   a_clamp_write: assert property (p_clamp_write) // [RULE1]
      else $error("Clamp code not stored.");

   property p_vmode_valid;
      @(posedge CLK) disable iff (!RST_B)
      (vmode_reg && CLAMP_CODE_VALID) |->
         (NEG_CLAMP_CODE inside {4'h2, 4'h7, 4'h9});
   endproperty
   a_vmode_valid: assert property (p_vmode_valid) // [RULE2]
      else $error("Invalid voltage mode clamp reported valid.");

   property p_high_invalid;
      @(posedge CLK) disable iff (!RST_B)
      (NEG_CLAMP_CODE[3] && (NEG_CLAMP_CODE[2:1] != 2'b00)) |->
         !CLAMP_CODE_VALID;
   endproperty
   a_high_invalid: assert property (p_high_invalid) // [RULE2]
      else $error("Code above 1001 reported valid.");

   property p_arm_off;
      @(posedge CLK) disable iff (!RST_B)
      (converter_arm_select_reg == 2'b00) |-> (!POS_ARM_EN && !NEG_ARM_EN);
   endproperty
   a_arm_off: assert property (p_arm_off) // [RULE3]
      else $error("Arm enabled with select 00.");

   property p_arm_pos;
      @(posedge CLK) disable iff (!RST_B)
      (wr_en && hit_arm && PWDATA[1:0] == 2'b01) |=>
         (POS_ARM_EN && !NEG_ARM_EN);
   endproperty
   a_arm_pos: assert property (p_arm_pos) // [RULE4]
      else $error("Select 01 did not enable positive arm only.");

   property p_arm_neg_both;
      @(posedge CLK) disable iff (!RST_B)
      (wr_en && hit_arm && PWDATA[1]) |=> (NEG_ARM_EN &&
         (POS_ARM_EN == $past(PWDATA[0])));
   endproperty
   a_arm_neg_both: assert property (p_arm_neg_both) // [RULE5]
      else $error("Select 10 or 11 gave wrong arm enables.");

   property p_cal_write;
      @(posedge CLK) disable iff (!RST_B)
      (wr_en && hit_cal) |=> (CAL_EN == $past(PWDATA[0]));
   endproperty
   a_cal_write: assert property (p_cal_write) // [RULE6]
      else $error("Calibration enable not stored.");

   property p_cal_hold;
      @(posedge CLK) disable iff (!RST_B)
      !(wr_en && hit_cal) |=> $stable(CAL_EN);
   endproperty
   a_cal_hold: assert property (p_cal_hold) // [RULE6]
      else $error("Calibration enable changed without a write.");

   property p_cur_valid;
      @(posedge CLK) disable iff (!RST_B)
      (!vmode_reg && (NEG_CLAMP_CODE <= 4'h9)) |-> CLAMP_CODE_VALID;
   endproperty
   a_cur_valid: assert property (p_cur_valid) // [RULE1]
      else $error("Current mode clamp code reported invalid.");

   property p_vmode_ok;
      @(posedge CLK) disable iff (!RST_B)
      (vmode_reg && (NEG_CLAMP_CODE inside {4'h2, 4'h7, 4'h9})) |->
         CLAMP_CODE_VALID;
   endproperty
   a_vmode_ok: assert property (p_vmode_ok) // [RULE2]
      else $error("Valid voltage mode clamp code reported invalid.");

   // A write to the arm and clamp word is a setup cycle, then an access.
   sequence s_arm_setup;
      PSEL && !PENABLE && PWRITE && hit_arm;
   endsequence

   sequence s_arm_access;
      PSEL && PENABLE && PWRITE && hit_arm;
   endsequence

   // The arms follow the stored select, so the store itself is checked.
   property p_arm_write;
      @(posedge CLK) disable iff (!RST_B)
      (s_arm_setup ##1 s_arm_access) |=>
         (converter_arm_select_reg == $past(PWDATA[1:0]));
   endproperty
   a_arm_write: assert property (p_arm_write) // [RULE3]
      else $error("Arm select not stored by a write.");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the clamp and calibration register bank.
// Assumes: Zero-wait APB slave; outputs follow one cycle after a write.
// Notes:   The mode input passes a two-stage synchroniser, so settle waits.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ------------------------------------------------------------
   // Signals and design
   // ------------------------------------------------------------
   logic        CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
   logic        PWRITE = 1'b0, VOLTAGE_MODE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic        PREADY, PSLVERR, POS_ARM_EN, NEG_ARM_EN;
   logic        CLAMP_CODE_VALID, CAL_EN, err;
   logic [3:0]  NEG_CLAMP_CODE;
   int          err_total = 0, compares = 0, cycles = 0;
   logic [7:0]  ac = clamp_cal_pkg::ARM_CLAMP_OFFSET;
   logic [7:0]  ce = clamp_cal_pkg::CAL_EN_OFFSET;
   clamp_cal_regs i_clamp_cal_regs (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .VOLTAGE_MODE(VOLTAGE_MODE), .POS_ARM_EN(POS_ARM_EN),
      .NEG_ARM_EN(NEG_ARM_EN), .NEG_CLAMP_CODE(NEG_CLAMP_CODE),
      .CLAMP_CODE_VALID(CLAMP_CODE_VALID), .CAL_EN(CAL_EN));
   always #25 CLK = ~CLK;
   // A hang anywhere is cut short well past the expected run length.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         results();
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1; PADDR <= a; PWRITE <= w; PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) begin
         @(posedge CLK);
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
      @(posedge CLK);
      #1;
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      logic v;
      repeat (6) @(posedge CLK);
      RST_B <= 1'b1;
      apb(ac, 1'b0, 32'h0);
      chk_word("arm_clamp reset", 32'h0, rd);
      chk_bit("pos arm reset", 1'b0, POS_ARM_EN);
      chk_bit("neg arm reset", 1'b0, NEG_ARM_EN);
      chk_bit("clamp valid reset", 1'b1, CLAMP_CODE_VALID);
      apb(ce, 1'b0, 32'h0);
      chk_word("cal reset", 32'h0, rd);
      chk_bit("cal_en reset", 1'b0, CAL_EN);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         apb(ac, 1'b1, 32'(i));
         chk_bit("pos arm", i[0], POS_ARM_EN);
         chk_bit("neg arm", i[1], NEG_ARM_EN);
      end
      $display("test arm select done");
      for (int m = 0; m < 2; m++) begin
         @(posedge CLK);
         VOLTAGE_MODE <= m[0];
         repeat (3) @(posedge CLK);
         for (int c = 0; c < 16; c++) begin
            v = m ? (c == 2 || c == 7 || c == 9) : (c <= 9);
            apb(ac, 1'b1, 32'hffffffc0 | 32'(c << 2) | 32'h1);
            apb(ac, 1'b0, 32'h0);
            chk_word("clamp readback", 32'(c << 2) | 32'h1, rd);
            chk_word("clamp code", 32'(c), 32'(NEG_CLAMP_CODE));
            chk_bit("clamp valid", v, CLAMP_CODE_VALID);
            chk_bit("pos arm kept", 1'b1, POS_ARM_EN);
         end
         apb(ac, 1'b1, {26'h0, clamp_cal_pkg::CLAMP_V_15, 2'b01});
         chk_bit("mode valid", 1'b1, CLAMP_CODE_VALID);
      end
      $display("test clamp codes done");
      apb(ce, 1'b1, 32'hffffffff);
      chk_bit("cal_en set", 1'b1, CAL_EN);
      apb(ce, 1'b0, 32'h0);
      chk_word("cal readback", 32'h1, rd);
      chk_bit("mapped error", 1'b0, err);
      apb(8'h0c, 1'b1, 32'h0);
      chk_bit("unmapped wr error", 1'b1, err);
      apb(8'h0c, 1'b0, 32'h0);
      chk_bit("unmapped error", 1'b1, err);
      chk_word("unmapped data", 32'h0, rd);
      chk_bit("cal_en held", 1'b1, CAL_EN);
      apb(ce, 1'b1, 32'h0);
      chk_bit("cal_en clear", 1'b0, CAL_EN);
      $display("test calibration done");
      results();
   end
endmodule
`default_nettype wire
